/* File: core/nand_copy_erase_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Start single erase only when the die reports ready on its busy pin.
// R2: Erase is 60h, three row address cycles with page bits zero, then D0h.
// R3: After the erase confirm the die stays busy for the block erase time.
// R4: Track completion by busy pin or status read, then check the fail bit.
// R5: With several dies, select one die with 78h status, never 70h.
// R6: Each 60h-address-D1h queues one block in the addressed plane.
// R7: After D1h wait for ready, then queue more or send final D0h.
// R8: Final D0h erases the last block plus every queued block.
// R9: Copy is 00h-35h read, wait ready, 85h-10h program, wait, check fail.
// R10: Copy read behaves as page read with 35h confirm instead of 30h.
// R11: Copy program opening 85h keeps the cache register contents.
// R12: Two-plane copy program queues a plane without clearing cache.
// R13: No copy across planes or dies; use read out and 80h-10h instead.
// R14: Between copy read and program allow only status and column changes.
// R15: Reset after copy read is allowed; cached data becomes invalid.
// R16: No operations on other dies from copy read until copy program.
// R17: Host may read out, correct and reload cached data before programming.
// R18: With internal ECC the die corrects cached data by itself.
// R19: Two-plane reads load several planes into their caches together.
// R20: 85h-11h commands before the final 85h-10h move several planes at once.
// R21: An 80h opening clears all caches unless a two-plane queue preceded it.
// R22: The die empties its plane queue when an operation starts or on reset.
module nand_copy_erase_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [nand_host_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [nand_host_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic nand_ce_n,
  output logic nand_cle,
  output logic nand_ale,
  output logic nand_we_n,
  output logic nand_re_n,
  output logic [7:0] nand_io_out,
  output logic nand_io_oe,
  input wire logic [7:0] nand_io_in,
  input wire logic nand_rb_n
);
  import nand_host_pkg::*;

  typedef enum {ST_IDLE, ST_WAIT_RDY, ST_ISSUE, ST_WAIT_DONE, ST_WAIT_WB, ST_WAIT_RB, ST_FINISH} seq_state_e;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_ROW) || (a == REG_COL) || (a == REG_DATA) || (a == REG_STATUS);
  endfunction : mapped

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m & mask;
  endfunction : apply_strb

  function automatic step_s mk(input logic last, input cyc_kind_e kind, input byte_src_e src,
                               input logic [7:0] cmd);
    step_s s;
    s.last = last;
    s.kind = kind;
    s.src = src;
    s.cmd = cmd;
    return s;
  endfunction : mk

  // Byte sequence of each operation; address cycles run column low, column high, then row low to high.
  function automatic step_s step_of(input op_e op, input logic [2:0] idx, input logic multi);
    step_s s;
    s = mk(1'b1, K_CMD, S_CMD, CMD_RESET);
    case (op)
      OP_ERASE, OP_ERASE_QUEUE: begin
        if (idx == 3'd0) s = mk(1'b0, K_CMD, S_CMD, CMD_ERASE_OPEN);
        else if (idx < 3'd4) s = mk(1'b0, K_ADDR, byte_src_e'(idx + 3'd2), 8'h00);
        else s = mk(1'b1, K_CMD, S_CMD, (op == OP_ERASE) ? CMD_ERASE_GO : CMD_ERASE_QUEUE);
      end
      OP_COPY_READ, OP_PLANE_READ, OP_PROG_OPEN: begin
        if (idx == 3'd0) s = mk(1'b0, K_CMD, S_CMD, (op == OP_PROG_OPEN) ? CMD_COPY_PROG_OPEN : CMD_READ_OPEN);
        else if (idx < 3'd6) s = mk(op != OP_COPY_READ && idx == 3'd5, K_ADDR, byte_src_e'(idx), 8'h00);
        else s = mk(1'b1, K_CMD, S_CMD, CMD_COPY_READ_GO);
      end
      OP_PROG_END: s = mk(1'b1, K_CMD, S_CMD, CMD_PROG_GO);
      OP_PROG_QUEUE: s = mk(1'b1, K_CMD, S_CMD, CMD_PROG_QUEUE);
      OP_COL_READ, OP_COL_WRITE: begin
        if (idx == 3'd0) s = mk(1'b0, K_CMD, S_CMD, (op == OP_COL_READ) ? CMD_COL_READ : CMD_COPY_PROG_OPEN);
        else if (idx < 3'd3) s = mk(op == OP_COL_WRITE && idx == 3'd2, K_ADDR, byte_src_e'(idx), 8'h00);
        else s = mk(1'b1, K_CMD, S_CMD, CMD_COL_READ_GO);
      end
      OP_DATA_OUT: s = mk(1'b1, K_RD, S_DATA, 8'h00);
      OP_DATA_IN: s = mk(1'b1, K_WR, S_DATA, 8'h00);
      OP_STATUS: begin
        if (idx == 3'd0) s = mk(1'b0, K_CMD, S_CMD, multi ? CMD_STATUS_DIE : CMD_STATUS);
        else if (multi && idx < 3'd4) s = mk(1'b0, K_ADDR, byte_src_e'(idx + 3'd2), 8'h00);
        else s = mk(1'b1, K_RD, S_DATA, 8'h00);
      end
      default: s = mk(1'b1, K_CMD, S_CMD, CMD_RESET);
    endcase
    return s;
  endfunction : step_of

  ////////////////////////////////////////////////////////////////////////////////
  // Register slave.

  logic [ADDR_W-1:0] aw_addr;
  logic aw_full;
  logic w_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] ctrl_word;
  logic [31:0] row_word;
  logic [31:0] col_word;
  logic [31:0] data_word;
  seq_state_e state;
  op_e op_cur;
  logic [2:0] step_idx;
  logic chk;
  logic [3:0] wb_cnt;
  logic busy;
  logic done_flag;
  logic fail;
  logic refused;
  logic copy_pending;
  logic [1:0] plane_mask;
  logic src_die;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  wire commit = aw_full && w_full && !bvalid;
  wire wr_ctrl = commit && (aw_addr == REG_CTRL);
  wire [31:0] ctrl_next = apply_strb(ctrl_word, w_data, w_strb, CTRL_MASK);
  wire multi_die = ctrl_word[CTRL_MULTI_BIT];
  wire start_go = wr_ctrl && w_strb[0] && w_data[CTRL_START_BIT] && (state == ST_IDLE);
  wire op_e op_req = op_e'(ctrl_next[3:0]);
  wire [31:0] status_word = {16'h0000, status_byte, plane_mask, nand_rb_n, copy_pending,
                             refused, fail, done_flag, busy};
  wire [31:0] read_word = (araddr == REG_CTRL) ? ctrl_word :
                          (araddr == REG_ROW) ? row_word :
                          (araddr == REG_COL) ? col_word :
                          (araddr == REG_DATA) ? {24'h00_0000, rd_byte} :
                          (araddr == REG_STATUS) ? status_word : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl_word <= CTRL_RESET;
      row_word <= 32'h0000_0000;
      col_word <= 32'h0000_0000;
      data_word <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_full <= 1'b1;
        awready <= 1'b0;
      end else if (!aw_full && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_full <= 1'b1;
        wready <= 1'b0;
      end else if (!w_full && !bvalid) begin
        wready <= 1'b1;
      end
      if (commit) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_DECERR;
        if (wr_ctrl) ctrl_word <= ctrl_next;
        if (aw_addr == REG_ROW) row_word <= apply_strb(row_word, w_data, w_strb, ROW_MASK);
        if (aw_addr == REG_COL) col_word <= apply_strb(col_word, w_data, w_strb, COL_MASK);
        if (aw_addr == REG_DATA) data_word <= apply_strb(data_word, w_data, w_strb, DATA_MASK);
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= read_word;
        rresp <= mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operation sequencer.

  nand_cycle_if cyc ();

  nand_pin_cycler u_cycler (
    .aclk(aclk),
    .aresetn(aresetn),
    .cyc(cyc.eng),
    .ce_n(nand_ce_n),
    .cle(nand_cle),
    .ale(nand_ale),
    .we_n(nand_we_n),
    .re_n(nand_re_n),
    .io_out(nand_io_out),
    .io_oe(nand_io_oe),
    .io_in(nand_io_in)
  );

  wire step_s step = step_of(op_cur, step_idx, multi_die);
  wire erase_op = (op_cur == OP_ERASE) || (op_cur == OP_ERASE_QUEUE);
  wire [23:0] row_eff = erase_op ? (row_word[23:0] & ~PAGE_MASK) : row_word[23:0]; // R2
  wire [7:0] cur_byte = (step.src == S_COL0) ? col_word[7:0] :
                        (step.src == S_COL1) ? col_word[15:8] :
                        (step.src == S_ROW0) ? row_eff[7:0] :
                        (step.src == S_ROW1) ? row_eff[15:8] :
                        (step.src == S_ROW2) ? row_eff[23:16] :
                        (step.src == S_DATA) ? data_word[7:0] : step.cmd;
  wire busy_op = erase_op || (op_cur == OP_COPY_READ) || (op_cur == OP_PROG_END) ||
                 (op_cur == OP_PROG_QUEUE) || (op_cur == OP_RESET); // R3 R7 R9
  wire req_plane = row_word[ROW_PLANE_BIT];
  wire other_die = row_word[ROW_DIE_BIT] != src_die;
  // A pending copy locks out everything but reset that would disturb the cached page or touch another die.
  wire refuse = (op_req > OP_RESET) ||
                (copy_pending && (op_req == OP_ERASE || op_req == OP_ERASE_QUEUE ||
                                  op_req == OP_COPY_READ || op_req == OP_PLANE_READ)) || // R14
                (copy_pending && op_req == OP_PROG_OPEN && (!plane_mask[req_plane] || other_die)) || // R13
                (copy_pending && op_req == OP_STATUS && ctrl_next[CTRL_MULTI_BIT] && other_die); // R16

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      op_cur <= OP_ERASE;
      step_idx <= 3'd0;
      chk <= 1'b0;
      wb_cnt <= 4'h0;
      cyc.req <= 1'b0;
      cyc.sel <= 1'b0;
      cyc.kind <= K_CMD;
      cyc.wbyte <= 8'h00;
      busy <= 1'b0;
      done_flag <= 1'b0;
      fail <= 1'b0;
      refused <= 1'b0;
      copy_pending <= 1'b0;
      plane_mask <= 2'h0;
      src_die <= 1'b0;
      status_byte <= 8'h00;
      rd_byte <= 8'h00;
    end else begin
      cyc.req <= 1'b0;
      case (state)
        ST_IDLE: if (start_go) begin
          done_flag <= refuse;
          refused <= refuse;
          if (!refuse) begin
            busy <= 1'b1;
            op_cur <= op_req;
            step_idx <= 3'd0;
            chk <= (op_req == OP_ERASE) || (op_req == OP_PROG_END); // R4 R9
            cyc.sel <= 1'b1;
            // Status reads are allowed while the die is busy; all else waits for ready.
            state <= (op_req == OP_STATUS) ? ST_ISSUE : ST_WAIT_RDY; // R1
          end
        end
        ST_WAIT_RDY: if (nand_rb_n) state <= ST_ISSUE; // R1 R7 R9
        ST_ISSUE: begin
          cyc.req <= 1'b1;
          cyc.kind <= step.kind;
          cyc.wbyte <= cur_byte;
          state <= ST_WAIT_DONE;
        end
        ST_WAIT_DONE: if (cyc.done) begin
          if (step.kind == K_RD && op_cur == OP_STATUS) begin
            status_byte <= cyc.rbyte;
            fail <= cyc.rbyte[STAT_FAIL_BIT]; // R4
          end else if (step.kind == K_RD) begin
            rd_byte <= cyc.rbyte; // R17
          end
          if (!step.last) begin
            step_idx <= step_idx + 3'd1;
            state <= ST_ISSUE;
          end else begin
            if (op_cur == OP_COPY_READ || op_cur == OP_PLANE_READ) begin
              plane_mask[req_plane] <= 1'b1; // R19
              src_die <= row_word[ROW_DIE_BIT];
            end
            if (op_cur == OP_COPY_READ) copy_pending <= 1'b1; // R14
            if (op_cur == OP_PROG_END || op_cur == OP_RESET) begin
              copy_pending <= 1'b0; // R15 R20
              plane_mask <= 2'h0;
            end
            wb_cnt <= WB_CYC - 4'h1;
            state <= busy_op ? ST_WAIT_WB : ST_FINISH; // R3
          end
        end
        ST_WAIT_WB: begin
          wb_cnt <= wb_cnt - 4'h1;
          if (wb_cnt == 4'h0) state <= ST_WAIT_RB;
        end
        ST_WAIT_RB: if (nand_rb_n) state <= ST_FINISH; // R4 R7
        ST_FINISH: if (chk) begin
          chk <= 1'b0;
          op_cur <= OP_STATUS; // R4 R5
          step_idx <= 3'd0;
          state <= ST_ISSUE;
        end else begin
          busy <= 1'b0;
          done_flag <= 1'b1;
          cyc.sel <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  issue_when_ready_a: assert property ( // R1
    state == ST_ISSUE && step_idx == 3'd0 && op_cur != OP_STATUS |-> $past(nand_rb_n))
    else $error("Operation issued while the die was busy.");
  erase_page_zero_a: assert property ( // R2
    state == ST_ISSUE && erase_op && step.src == S_ROW0 |=> cyc.req && cyc.wbyte[5:0] == 6'h00)
    else $error("Erase row carried page bits.");
  erase_busy_wait_a: assert property ( // R3
    state == ST_WAIT_DONE && cyc.done && step.last && op_cur == OP_ERASE
    |=> state == ST_WAIT_WB && wb_cnt == WB_CYC - 4'h1)
    else $error("Erase confirm not followed by the busy wait.");
  check_after_op_a: assert property ( // R4
    state == ST_WAIT_RB && nand_rb_n && chk |=> ##1 state == ST_ISSUE && op_cur == OP_STATUS)
    else $error("Fail bit not checked after completion.");
  fail_capture_a: assert property ( // R4
    state == ST_WAIT_DONE && cyc.done && op_cur == OP_STATUS && step.kind == K_RD
    |=> fail == $past(cyc.rbyte[STAT_FAIL_BIT]))
    else $error("Fail flag does not follow the status byte.");
  die_status_a: assert property ( // R5
    cyc.req && cyc.kind == K_CMD && multi_die |-> cyc.wbyte != CMD_STATUS)
    else $error("Plain status read used with several dies.");
  queue_ready_a: assert property ( // R7
    state == ST_FINISH && $past(state == ST_WAIT_RB) |-> $past(nand_rb_n))
    else $error("Queued operation finished before ready.");
  copy_lock_a: assert property ( // R14
    start_go && copy_pending && op_req == OP_ERASE |=> refused && done_flag && state == ST_IDLE)
    else $error("Erase accepted during a pending copy.");
  plane_lock_a: assert property ( // R13
    start_go && copy_pending && op_req == OP_PROG_OPEN && !plane_mask[req_plane] |=> refused)
    else $error("Copy program to another plane accepted.");
  reset_unlock_a: assert property ( // R15
    state == ST_WAIT_DONE && cyc.done && op_cur == OP_RESET |=> !copy_pending && plane_mask == 2'h0)
    else $error("Reset left a copy pending.");

endmodule : nand_copy_erase_host
`default_nettype wire

/* File: core/nand_host_pkg.sv */
package nand_host_pkg;

  // Bus and register map.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ROW = 8'h04;
  localparam logic [ADDR_W-1:0] REG_COL = 8'h08;
  localparam logic [ADDR_W-1:0] REG_DATA = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam logic [31:0] CTRL_MASK = 32'h0000_010f;
  localparam logic [31:0] ROW_MASK = 32'h00ff_ffff;
  localparam logic [31:0] COL_MASK = 32'h0000_ffff;
  localparam logic [31:0] DATA_MASK = 32'h0000_00ff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_START_BIT = 4;
  localparam int CTRL_MULTI_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Row address layout and status byte.
  localparam logic [23:0] PAGE_MASK = 24'h00_003f;
  localparam int ROW_PLANE_BIT = 6;
  localparam int ROW_DIE_BIT = 17;
  localparam int STAT_FAIL_BIT = 0;

  // Timing, in nanoseconds and in cycles of aclk.
  localparam int CLK_NS = 10;
  localparam int T_SETUP_NS = 10;
  localparam int T_STROBE_LOW_NS = 12;
  localparam int T_STROBE_HIGH_NS = 10;
  localparam int T_WB_NS = 100;
  function automatic int cyc_up(input int ns);
    return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction : cyc_up
  localparam logic [3:0] SETUP_CYC = 4'(cyc_up(T_SETUP_NS));
  localparam logic [3:0] LOW_CYC = 4'(cyc_up(T_STROBE_LOW_NS));
  localparam logic [3:0] HIGH_CYC = 4'(cyc_up(T_STROBE_HIGH_NS));
  localparam logic [3:0] WB_CYC = 4'(cyc_up(T_WB_NS));

  // Command bytes.
  localparam logic [7:0] CMD_READ_OPEN = 8'h00;
  localparam logic [7:0] CMD_COPY_READ_GO = 8'h35;
  localparam logic [7:0] CMD_COPY_PROG_OPEN = 8'h85;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_PROG_QUEUE = 8'h11;
  localparam logic [7:0] CMD_ERASE_OPEN = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_ERASE_QUEUE = 8'hd1;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_DIE = 8'h78;
  localparam logic [7:0] CMD_COL_READ = 8'h05;
  localparam logic [7:0] CMD_COL_READ_GO = 8'he0;
  localparam logic [7:0] CMD_RESET = 8'hff;

  typedef enum logic [3:0] {
    OP_ERASE, OP_ERASE_QUEUE, OP_COPY_READ, OP_PLANE_READ, OP_PROG_OPEN, OP_PROG_END,
    OP_PROG_QUEUE, OP_COL_READ, OP_COL_WRITE, OP_DATA_OUT, OP_DATA_IN, OP_STATUS, OP_RESET
  } op_e;
  typedef enum logic [1:0] {K_CMD, K_ADDR, K_WR, K_RD} cyc_kind_e;
  typedef enum logic [2:0] {S_CMD, S_COL0, S_COL1, S_ROW0, S_ROW1, S_ROW2, S_DATA} byte_src_e;
  typedef struct packed {
    logic last;
    cyc_kind_e kind;
    byte_src_e src;
    logic [7:0] cmd;
  } step_s;

endpackage : nand_host_pkg

/* File: core/nand_cycle_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface nand_cycle_if;
  logic req;
  logic sel;
  nand_host_pkg::cyc_kind_e kind;
  logic [7:0] wbyte;
  logic done;
  logic [7:0] rbyte;
  modport seq (output req, sel, kind, wbyte, input done, rbyte);
  modport eng (input req, sel, kind, wbyte, output done, rbyte);
endinterface : nand_cycle_if
`default_nettype wire

/* File: core/nand_pin_cycler.sv */
`timescale 1ns/1ps
`default_nettype none
module nand_pin_cycler (
  input wire logic aclk,
  input wire logic aresetn,
  nand_cycle_if.eng cyc,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in
);
  import nand_host_pkg::*;

  typedef enum {P_IDLE, P_SETUP, P_LOW, P_HIGH} phase_e;
  phase_e phase;
  logic [3:0] cnt;
  cyc_kind_e kind_r;
  wire is_rd = (kind_r == K_RD);
  wire cnt_zero = (cnt == 4'h0);

  // Latch levels and data settle one phase before the strobe falls and hold one phase after it rises.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= P_IDLE;
      cnt <= 4'h0;
      kind_r <= K_CMD;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      cyc.done <= 1'b0;
      cyc.rbyte <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      ce_n <= !cyc.sel;
      case (phase)
        P_IDLE: if (cyc.req) begin
          kind_r <= cyc.kind;
          cle <= (cyc.kind == K_CMD);
          ale <= (cyc.kind == K_ADDR);
          io_out <= cyc.wbyte;
          io_oe <= (cyc.kind != K_RD);
          cnt <= SETUP_CYC - 4'h1;
          phase <= P_SETUP;
        end
        P_SETUP: if (cnt_zero) begin
          we_n <= is_rd;
          re_n <= !is_rd;
          cnt <= LOW_CYC - 4'h1;
          phase <= P_LOW;
        end else begin
          cnt <= cnt - 4'h1;
        end
        P_LOW: if (cnt_zero) begin
          we_n <= 1'b1;
          re_n <= 1'b1;
          if (is_rd) begin
            cyc.rbyte <= io_in;
          end
          cnt <= HIGH_CYC - 4'h1;
          phase <= P_HIGH;
        end else begin
          cnt <= cnt - 4'h1;
        end
        P_HIGH: if (cnt_zero) begin
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe <= 1'b0;
          cyc.done <= 1'b1;
          phase <= P_IDLE;
        end else begin
          cnt <= cnt - 4'h1;
        end
        default: phase <= P_IDLE;
      endcase
    end
  end

  strobe_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(we_n) |-> !we_n [*2] ##1 we_n) else $error("Write strobe low time is wrong.");
  read_no_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !re_n |-> !io_oe && !we_n == 1'b0) else $error("Data bus driven during a read strobe.");

endmodule : nand_pin_cycler
`default_nettype wire

/* File: test/nand_die_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nand_die_model #(
  parameter int ERASE_CYC = 40,
  parameter int QUEUE_CYC = 6
) (
  input wire logic aclk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic fail_en,
  output logic [7:0] io_in,
  output logic rb_n
);
  logic [7:0] log_q[$];
  logic [7:0] last = 8'h00;
  logic fail = 1'b0;
  logic cache_ok = 1'b0;
  logic prev_we = 1'b1;
  int busy_cnt = 0;
  int queued = 0;
  assign rb_n = (busy_cnt == 0);
  // A released bus shows the inverse of the last byte, so a stale sample cannot pass.
  assign io_in = (!ce_n && !re_n) ? {1'b1, rb_n, rb_n, 4'h0, fail} : ~last;
  always @(posedge aclk) begin
    prev_we <= we_n;
    if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
    if (!re_n) begin
      last <= io_in;
    end
    // A byte latched while the host has its driver off is lost, so a bad enable shows in the log.
    if (!ce_n && we_n && !prev_we && (cle || ale) && io_oe) begin
      log_q.push_back(io_out);
      if (cle && busy_cnt == 0) begin
        case (io_out)
          8'hd0, 8'h10: begin busy_cnt <= ERASE_CYC; fail <= fail_en; queued <= 0; end
          8'hd1, 8'h11: begin busy_cnt <= QUEUE_CYC; queued <= queued + 1; end
          8'h35, 8'h30: begin busy_cnt <= QUEUE_CYC; cache_ok <= 1'b1; end
          8'hff: begin busy_cnt <= QUEUE_CYC; cache_ok <= 1'b0; queued <= 0; end
          8'h80: if (queued == 0) cache_ok <= 1'b0;
          default: ;
        endcase
      end
    end
  end
endmodule : nand_die_model
`default_nettype wire

/* File: test/nand_copy_erase_host_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module nand_copy_erase_host_tb_top;
  import nand_host_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, fail_en = 1'b0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, nand_ce_n, nand_cle, nand_ale, nand_we_n, nand_re_n;
  logic nand_io_oe, nand_rb_n;
  logic [1:0] bresp, rresp, rr;
  logic [7:0] nand_io_out, nand_io_in;
  int fails = 0, checks_done = 0;
  always #5 aclk = ~aclk;
  nand_copy_erase_host dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .nand_ce_n,
    .nand_cle, .nand_ale, .nand_we_n, .nand_re_n, .nand_io_out, .nand_io_oe, .nand_io_in, .nand_rb_n);
  nand_die_model m (.aclk, .ce_n(nand_ce_n), .cle(nand_cle), .ale(nand_ale), .we_n(nand_we_n),
    .re_n(nand_re_n), .io_out(nand_io_out), .io_oe(nand_io_oe), .fail_en, .io_in(nand_io_in), .rb_n(nand_rb_n));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (!bvalid);
    rr = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!(arvalid && arready));
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata; rr = rresp; rready <= 1'b0;
  endtask : rd_reg
  task automatic run_op(input logic [3:0] op, input logic multi, input logic [23:0] row);
    int n;
    n = 0;
    wr(REG_ROW, {8'h00, row});
    wr(REG_CTRL, {23'h0, multi, 3'h0, 1'b1, op});
    do begin rd_reg(REG_STATUS); n++; end while (rd[0] !== 1'b0 && n < 500);
    check("op busy", 1'b0, rd[0]);
  endtask : run_op
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_reg(REG_CTRL);
    check("ctrl reset", CTRL_RESET, rd);
    rd_reg(8'h40);
    check("unmapped read", {RESP_DECERR, 32'h0}, {rr, rd});
    wr(8'h44, 32'h1);
    check("unmapped write", RESP_DECERR, rr);
    $display("regs done");
  endtask : t_regs
  task automatic t_erase;
    m.log_q.delete();
    run_op(4'd0, 1'b0, 24'h02_0047);
    check("erase bytes", 48'h60_4000_02d0_70, {m.log_q[0], m.log_q[1], m.log_q[2], m.log_q[3], m.log_q[4], m.log_q[5]});
    check("erase done ok", 2'b01, rd[2:1]);
    fail_en <= 1'b1;
    m.log_q.delete();
    run_op(4'd0, 1'b1, 24'h02_0000);
    check("die status", 8'h78, m.log_q[5]);
    check("erase fail", 1'b1, rd[2]);
    fail_en <= 1'b0;
    $display("erase done");
  endtask : t_erase
  task automatic t_queue;
    m.log_q.delete();
    run_op(4'd1, 1'b0, 24'h00_0000);
    check("queued planes", 1, m.queued);
    run_op(4'd0, 1'b0, 24'h00_0040);
    check("queue emptied", 0, m.queued);
    check("queue confirm", 16'hd1_60, {m.log_q[4], m.log_q[5]});
    check("final erase", 16'h40_d0, {m.log_q[6], m.log_q[9]});
    $display("queue done");
  endtask : t_queue
  task automatic t_copy;
    m.log_q.delete();
    run_op(4'd2, 1'b0, 24'h00_0005);
    check("copy read", 16'h00_35, {m.log_q[0], m.log_q[6]});
    check("copy pending", 1'b1, rd[4]);
    run_op(4'd0, 1'b0, 24'h00_0005);
    check("refused erase", 32'h8000_0007, {rd[3], 24'h0, 7'(m.log_q.size())});
    run_op(4'd4, 1'b0, 24'h00_0009);
    run_op(4'd5, 1'b0, 24'h00_0009);
    check("copy program", 16'h85_10, {m.log_q[7], m.log_q[13]});
    check("pending cleared", 1'b0, rd[4]);
    run_op(4'd2, 1'b0, 24'h00_0005);
    run_op(4'd4, 1'b0, 24'h00_0045);
    check("refused plane", 1'b1, rd[3]);
    run_op(4'd11, 1'b1, 24'h02_0005);
    check("refused die", 1'b1, rd[3]);
    run_op(4'd12, 1'b0, 24'h00_0000);
    check("reset unlock", 3'b000, {rd[4], rd[3], m.cache_ok});
    $display("copy done");
  endtask : t_copy
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #300_000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_erase();
    t_queue();
    t_copy();
    wrap_up();
  end
endmodule : nand_copy_erase_host_tb_top
`default_nettype wire
